/* src/rwi_params.svh */
// Constants for the reset, wake-up and interrupt source block.
// Assumes a 10 MHz core clock and byte offsets taken from the low eight address bits.
`ifndef RWI_PARAMS_SVH
`define RWI_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RWI_OFS_ICON      8'h00
`define RWI_OFS_OPTION    8'h04
`define RWI_OFS_CAUSE     8'h08
`define RWI_OFS_CTRL      8'h0c
`define RWI_OFS_TRISA     8'h10
`define RWI_OFS_TRISB     8'h14
`define RWI_OFS_TRISC     8'h18
`define RWI_OFS_KEEP      8'h1c
`define RWI_OFS_RESTART   8'h20
`define RWI_OFS_IRQ_STAT  8'h24
`define RWI_OFS_IRQ_MASK  8'h28

// ****************************************************************
// Reset values and addresses
// ****************************************************************
`define RWI_ICON_RST      8'h00
`define RWI_OPTION_RST    8'hff
`define RWI_TRISA_RST     6'h3f
`define RWI_TRISB_RST     8'hff
`define RWI_TRISC_RST     8'hff
`define RWI_IRQ_RST       5'h00
`define RWI_RESTART_ADDR  13'h0000
`define RWI_VECTOR_ADDR   13'h0004

// ****************************************************************
// Field positions
// ****************************************************************
`define RWI_EDGE_SEL_BIT  6
`define RWI_CTRL_SLEEP    0
`define RWI_CTRL_CLRWDT   1
`define RWI_EV_PORT       0
`define RWI_EV_EDGE       1
`define RWI_EV_TIMER      2
`define RWI_EV_RESET      3
`define RWI_EV_WAKE       4
`define RWI_T0_TOP        8'hff
`define RWI_T0_ZERO       8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define RWI_CLK_MHZ       10
`define RWI_EXT_RST_MIN_NS 2000
`define RWI_EXT_RST_MIN_CYC (((`RWI_EXT_RST_MIN_NS * `RWI_CLK_MHZ) + 999) / 1000)
`define RWI_FILT_W        8

`endif

/* src/rwi_pkg.sv */
// Types shared by the reset, wake-up and interrupt source block.
// Assumes nothing beyond a SystemVerilog compiler.
package rwi_pkg;

  // ****************************************************************
  // Reset and wake classification
  // ****************************************************************
  typedef enum logic [2:0] {
    KIND_POR      = 3'b000,
    KIND_EXT_RUN  = 3'b001,
    KIND_EXT_HALT = 3'b010,
    KIND_WDT_RUN  = 3'b011,
    KIND_WDT_WAKE = 3'b100,
    KIND_BOR      = 3'b101,
    KIND_IRQ_WAKE = 3'b110
  } rwi_kind_type;

  typedef enum logic {
    ST_RUN  = 1'b0,
    ST_HALT = 1'b1
  } rwi_state_type;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic global_irq_enable;
    logic periph_enable;
    logic timer0_overflow_enable;
    logic ext_edge_enable;
    logic upper_port_change_enable;
    logic timer0_overflow_flag;
    logic ext_edge_flag;
    logic upper_port_change_flag;
  } rwi_icon_type;

  typedef struct packed {
    rwi_kind_type kind;
    logic         timeout_status_n;
    logic         powerdown_status_n;
  } rwi_cause_type;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } rwi_ahb_in_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } rwi_ahb_out_type;

  typedef struct packed {
    logic        core_reset;
    logic        pc_load;
    logic [12:0] pc_addr;
    logic        stack_push;
    logic [12:0] stack_data;
  } rwi_core_type;

endpackage

/* src/rwi_reset_filter.sv */
// Glitch filter for the external active-low reset pin.
// Assumes the pin is already synchronous to hclk.
`timescale 1ns/1ns
`include "rwi_params.svh"

module rwi_reset_filter (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ext_reset_pin_n,
  output logic      accepted,
  output logic      accept_pulse
);
  import rwi_pkg::*;

  localparam logic [`RWI_FILT_W-1:0] MIN_CYC = `RWI_FILT_W'(`RWI_EXT_RST_MIN_CYC);

  logic [`RWI_FILT_W-1:0] low_count;

  // ****************************************************************
  // Low-time counter
  // ****************************************************************
  // Short low pulses restart the count and never reach the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_count <= '0;
    end else if (ext_reset_pin_n) begin
      low_count <= '0;
    end else if (low_count != MIN_CYC) begin
      low_count <= low_count + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accepted     <= 1'b0;
      accept_pulse <= 1'b0;
    end else begin
      accepted     <= !ext_reset_pin_n && (low_count == MIN_CYC);
      accept_pulse <= !ext_reset_pin_n && (low_count == MIN_CYC - 1'b1);
    end
  end

endmodule

/* src/rwi_top.sv */
// Reset classification, wake-up control and three interrupt flag sources.
// Assumes an AHB-Lite master, hresetn as power-on reset, synchronous pin inputs.
`timescale 1ns/1ns
`include "rwi_params.svh"

// Overview of operation
// - Each reset is classed: power-on, pin run, pin halt, watchdog run, watchdog wake, brown-out.
// - Reset-state registers reload on every reset except watchdog wake from halt.
// - Some registers are never reset; they keep their value over all resets.
// - Timeout and power-down status bits are set or cleared per reset kind.
// - External reset pin is glitch-filtered; pulses shorter than minimum width ignored.
// - No internal reset source ever drives the external reset pin; it is input only.
// - Interrupt wake with global enable set loads the interrupt vector address.
// - Any reset makes the port A pins inputs.
// - Interrupt wake leaves its source flag set to identify the wake cause.
// - External pin edge is rising when edge-select bit 6 is one, else falling.
// - A selected edge sets the external edge flag, control bit 1.
// - Clearing enable bit 4 stops the external edge flag raising an interrupt.
// - External edge flag stays set until software writes zero to it or a reset clears it.
// - Edge wakes halt only if enabled; global enable picks vector or continue.
// - Timer-0 rollover from FFh to 00h sets flag bit 2; bit 5 enables it.
// - Any change on port B bits 7 to 4 sets flag bit 0, own enable.
// - Interrupt entry pushes only the return address; nothing else is saved.
module rwi_top (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire rwi_pkg::rwi_ahb_in_type   ahb_in,
  output rwi_pkg::rwi_ahb_out_type       ahb_out,
  input  wire logic                      ext_reset_pin_n,
  input  wire logic                      brownout_reset,
  input  wire logic                      watchdog_timeout,
  input  wire logic                      ext_irq_pin,
  input  wire logic [7:0]                timer0_count,
  input  wire logic [7:4]                port_b_pins,
  input  wire logic                      peripheral_irq_pending,
  input  wire logic [12:0]               return_pc,
  output rwi_pkg::rwi_core_type          core,
  output logic                           halted,
  output logic [5:0]                     port_a_dir,
  output logic [7:0]                     port_b_dir,
  output logic [7:0]                     port_c_dir,
  output logic                           irq
);
  import rwi_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  rwi_icon_type  interrupt_control;
  rwi_cause_type cause;
  rwi_state_type state;
  rwi_kind_type  next_kind;
  logic [7:0]    option;
  logic [5:0]    tris_a;
  logic [7:0]    tris_b;
  logic [7:0]    tris_c;
  logic [7:0]    keep_reg;
  logic [12:0]   restart_addr;
  logic [4:0]    irq_status;
  logic [4:0]    irq_mask;
  logic [4:0]    irq_events;
  logic          wr_pend;
  logic [7:0]    wr_ofs;
  logic [31:0]   rd_word;
  logic [31:0]   hrdata_q;
  logic          take;
  logic          ext_accepted;
  logic          ext_pulse;
  logic          ext_prev;
  logic [7:0]    t0_prev;
  logic [7:4]    pb_prev;
  logic          bor_prev;
  logic          edge_evt;
  logic          t0_evt;
  logic          pb_evt;
  logic          bor_evt;
  logic          wdt_run_evt;
  logic          wdt_wake_evt;
  logic          any_reset;
  logic          kind_evt;
  logic          pending;
  logic          irq_wake;
  logic          vector_go;
  logic          icon_wr;
  logic          sleep_cmd;
  logic          clrwdt_cmd;

  // ****************************************************************
  // Decode helper
  // ****************************************************************
  function automatic logic ofs_hit(input logic [7:0] a, input logic [7:0] o);
    ofs_hit = (a[7:2] == o[7:2]);
  endfunction

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states; read data is captured in the address phase
  assign take = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
    end else begin
      wr_pend <= take && ahb_in.hwrite;
      if (take) begin
        wr_ofs <= ahb_in.haddr[7:0];
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_ICON)) begin
      rd_word[7:0] = interrupt_control;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_OPTION)) begin
      rd_word[7:0] = option;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_CAUSE)) begin
      rd_word[4:0] = cause;
      rd_word[5]   = halted;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_TRISA)) begin
      rd_word[5:0] = tris_a;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_TRISB)) begin
      rd_word[7:0] = tris_b;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_TRISC)) begin
      rd_word[7:0] = tris_c;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_KEEP)) begin
      rd_word[7:0] = keep_reg;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_RESTART)) begin
      rd_word[12:0] = restart_addr;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_IRQ_STAT)) begin
      rd_word[4:0] = irq_status;
    end else if (ofs_hit(ahb_in.haddr[7:0], `RWI_OFS_IRQ_MASK)) begin
      rd_word[4:0] = irq_mask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (take && !ahb_in.hwrite) begin
      hrdata_q <= rd_word;
    end
  end

  assign ahb_out.hrdata    = hrdata_q;
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp     = 1'b0;

  assign icon_wr    = wr_pend && ofs_hit(wr_ofs, `RWI_OFS_ICON);
  assign sleep_cmd  = wr_pend && ofs_hit(wr_ofs, `RWI_OFS_CTRL) &&
                      ahb_in.hwdata[`RWI_CTRL_SLEEP];
  assign clrwdt_cmd = wr_pend && ofs_hit(wr_ofs, `RWI_OFS_CTRL) &&
                      ahb_in.hwdata[`RWI_CTRL_CLRWDT];

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  // Pin is only observed here; no output path exists toward it
  rwi_reset_filter u_filter (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .ext_reset_pin_n (ext_reset_pin_n),
    .accepted        (ext_accepted),
    .accept_pulse    (ext_pulse)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bor_prev <= 1'b0;
    end else begin
      bor_prev <= brownout_reset;
    end
  end

  assign bor_evt      = brownout_reset && !bor_prev;
  assign wdt_run_evt  = watchdog_timeout && (state == ST_RUN);
  assign wdt_wake_evt = watchdog_timeout && (state == ST_HALT);
  assign any_reset    = bor_evt || ext_pulse || wdt_run_evt;
  assign kind_evt     = any_reset || wdt_wake_evt || irq_wake;

  // Brown-out outranks the pin, the pin outranks the watchdog
  always_comb begin
    next_kind = cause.kind;
    if (bor_evt) begin
      next_kind = KIND_BOR;
    end else if (ext_pulse) begin
      next_kind = (state == ST_HALT) ? KIND_EXT_HALT : KIND_EXT_RUN;
    end else if (wdt_run_evt) begin
      next_kind = KIND_WDT_RUN;
    end else if (wdt_wake_evt) begin
      next_kind = KIND_WDT_WAKE;
    end else if (irq_wake) begin
      next_kind = KIND_IRQ_WAKE;
    end
  end

  // ****************************************************************
  // Cause and status bits
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause <= '{kind: KIND_POR, timeout_status_n: 1'b1, powerdown_status_n: 1'b1};
    end else begin
      cause.kind <= next_kind;
      // Outside events only the halt and clear commands touch the status bits
      case (kind_evt ? next_kind : KIND_POR)
        KIND_BOR: begin
          cause.timeout_status_n   <= 1'b1;
          cause.powerdown_status_n <= 1'b1;
        end
        KIND_EXT_HALT, KIND_IRQ_WAKE: begin
          cause.timeout_status_n   <= 1'b1;
          cause.powerdown_status_n <= 1'b0;
        end
        KIND_WDT_RUN: begin
          cause.timeout_status_n   <= 1'b0;
        end
        KIND_WDT_WAKE: begin
          cause.timeout_status_n   <= 1'b0;
          cause.powerdown_status_n <= 1'b0;
        end
        default: begin
          if (sleep_cmd) begin
            cause.timeout_status_n   <= 1'b1;
            cause.powerdown_status_n <= 1'b0;
          end else if (clrwdt_cmd) begin
            cause.timeout_status_n   <= 1'b1;
            cause.powerdown_status_n <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Run and halt
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          if (sleep_cmd && !any_reset) begin
            state <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (any_reset || wdt_wake_evt || irq_wake) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  assign halted = (state == ST_HALT);

  // ****************************************************************
  // Interrupt flag sources
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev <= 1'b0;
      t0_prev  <= `RWI_T0_ZERO;
      pb_prev  <= 4'h0;
    end else begin
      ext_prev <= ext_irq_pin;
      t0_prev  <= timer0_count;
      pb_prev  <= port_b_pins;
    end
  end

  assign edge_evt = option[`RWI_EDGE_SEL_BIT] ? (ext_irq_pin && !ext_prev)
                                              : (!ext_irq_pin && ext_prev);
  assign t0_evt   = (t0_prev == `RWI_T0_TOP) && (timer0_count == `RWI_T0_ZERO);
  assign pb_evt   = (pb_prev != port_b_pins);

  // Enables gate the request, never the flag itself
  assign pending = (interrupt_control.ext_edge_enable && interrupt_control.ext_edge_flag) ||
                   (interrupt_control.timer0_overflow_enable &&
                    interrupt_control.timer0_overflow_flag) ||
                   (interrupt_control.upper_port_change_enable &&
                    interrupt_control.upper_port_change_flag) ||
                   (interrupt_control.periph_enable && peripheral_irq_pending);

  // Wake needs the source enable only; global enable just picks the path
  assign irq_wake  = halted && pending && !any_reset && !wdt_wake_evt;
  assign vector_go = interrupt_control.global_irq_enable && pending && !any_reset;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_control <= `RWI_ICON_RST;
    end else if (any_reset) begin
      interrupt_control <= `RWI_ICON_RST;
    end else begin
      if (icon_wr) begin
        interrupt_control <= ahb_in.hwdata[7:0];
      end
      if (vector_go) begin
        interrupt_control.global_irq_enable <= 1'b0;
      end
      // Hardware set beats a software clear in the same cycle; flags kept for wake source
      if (edge_evt) begin
        interrupt_control.ext_edge_flag <= 1'b1;
      end
      if (t0_evt) begin
        interrupt_control.timer0_overflow_flag <= 1'b1;
      end
      if (pb_evt) begin
        interrupt_control.upper_port_change_flag <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Reset-state registers
  // ****************************************************************
  // Watchdog wake is not a reset, so these keep their value across it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      option <= `RWI_OPTION_RST;
      tris_a <= `RWI_TRISA_RST;
      tris_b <= `RWI_TRISB_RST;
      tris_c <= `RWI_TRISC_RST;
    end else if (any_reset) begin
      option <= `RWI_OPTION_RST;
      tris_a <= `RWI_TRISA_RST;
      tris_b <= `RWI_TRISB_RST;
      tris_c <= `RWI_TRISC_RST;
    end else if (wr_pend) begin
      if (ofs_hit(wr_ofs, `RWI_OFS_OPTION)) begin
        option <= ahb_in.hwdata[7:0];
      end
      if (ofs_hit(wr_ofs, `RWI_OFS_TRISA)) begin
        tris_a <= ahb_in.hwdata[5:0];
      end
      if (ofs_hit(wr_ofs, `RWI_OFS_TRISB)) begin
        tris_b <= ahb_in.hwdata[7:0];
      end
      if (ofs_hit(wr_ofs, `RWI_OFS_TRISC)) begin
        tris_c <= ahb_in.hwdata[7:0];
      end
    end
  end

  assign port_a_dir = tris_a;
  assign port_b_dir = tris_b;
  assign port_c_dir = tris_c;

  // No reset term at all: undefined after power-on, held across the rest
  always_ff @(posedge hclk) begin
    if (wr_pend && ofs_hit(wr_ofs, `RWI_OFS_KEEP)) begin
      keep_reg <= ahb_in.hwdata[7:0];
    end
  end

  // ****************************************************************
  // Core restart and vectoring
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core         <= '{core_reset: 1'b1, pc_load: 1'b1, pc_addr: `RWI_RESTART_ADDR,
                        stack_push: 1'b0, stack_data: 13'h0000};
      restart_addr <= `RWI_RESTART_ADDR;
    end else begin
      core.core_reset <= any_reset || ext_accepted || brownout_reset;
      core.pc_load    <= any_reset || vector_go;
      core.stack_push <= vector_go;
      if (vector_go) begin
        core.stack_data <= return_pc;
      end
      if (any_reset) begin
        core.pc_addr <= `RWI_RESTART_ADDR;
        restart_addr <= `RWI_RESTART_ADDR;
      end else if (vector_go) begin
        core.pc_addr <= `RWI_VECTOR_ADDR;
        restart_addr <= `RWI_VECTOR_ADDR;
      end else if (irq_wake || wdt_wake_evt) begin
        restart_addr <= return_pc;
      end
    end
  end

  // ****************************************************************
  // Event status and interrupt line
  // ****************************************************************
  always_comb begin
    irq_events                = 5'h00;
    irq_events[`RWI_EV_PORT]  = pb_evt;
    irq_events[`RWI_EV_EDGE]  = edge_evt;
    irq_events[`RWI_EV_TIMER] = t0_evt;
    irq_events[`RWI_EV_RESET] = any_reset;
    irq_events[`RWI_EV_WAKE]  = irq_wake || wdt_wake_evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= `RWI_IRQ_RST;
      irq_mask   <= `RWI_IRQ_RST;
    end else begin
      if (wr_pend && ofs_hit(wr_ofs, `RWI_OFS_IRQ_STAT)) begin
        irq_status <= (irq_status & ~ahb_in.hwdata[4:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      if (wr_pend && ofs_hit(wr_ofs, `RWI_OFS_IRQ_MASK)) begin
        irq_mask <= ahb_in.hwdata[4:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule

/* tb/rwi_pins.sv */
// Pin model: external reset driver and interrupt pin.
// Assumes its tasks are called just after a rising edge.
`timescale 1ns/1ns
// ****
// Pins
// ****
module rwi_pins (
  input wire logic hclk,
  output logic     ext_reset_pin_n,
  output logic     ext_irq_pin
);
  initial begin
    ext_reset_pin_n = 1'b1;
    ext_irq_pin = 1'b0;
  end
  task automatic rst_low(input int n);
    ext_reset_pin_n <= 1'b0;
    repeat (n) @(posedge hclk);
    ext_reset_pin_n <= 1'b1;
  endtask
  task automatic irq_pin(input logic v);
    ext_irq_pin <= v;
    repeat (2) @(posedge hclk);
  endtask
endmodule

/* tb/rwi_top_props.sv */
// Checker for rwi_top: reset, wake and vector timing at its ports.
// Assumes hclk is the only clock; bound onto every rwi_top.
`timescale 1ns/1ns
// ****
// Checker
// ****
module rwi_top_props (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  ext_reset_pin_n,
  input wire logic                  brownout_reset,
  input wire logic                  watchdog_timeout,
  input wire logic [12:0]           return_pc,
  input wire rwi_pkg::rwi_core_type core,
  input wire logic                  halted,
  input wire logic [5:0]            port_a_dir
);
  import rwi_pkg::*;
  logic [7:0] low_cnt;
  // Saturates so a stuck pin cannot wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt <= 8'h00;
    else if (ext_reset_pin_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_WDT_PC: assert property (watchdog_timeout && !halted |=> core.pc_load && !core.pc_addr)
    else $error("watchdog reset not at zero");
  AST_DIR_A: assert property (watchdog_timeout && !halted |-> ##[1:2] port_a_dir == 6'h3f)
    else $error("port a not inputs");
  AST_WAKE: assert property (
    watchdog_timeout && halted && ext_reset_pin_n && !brownout_reset
    |=> !core.core_reset && !halted) else $error("watchdog wake reset");
  AST_VEC: assert property (core.stack_push |-> core.pc_load && core.pc_addr == 13'h0004)
    else $error("bad vector");
  AST_PUSH: assert property (core.stack_push |-> core.stack_data == $past(return_pc))
    else $error("bad pushed address");
  AST_GLITCH: assert property (
    low_cnt inside {[8'h01:8'h0f]} && !brownout_reset && !$past(watchdog_timeout)
    |-> !core.core_reset) else $error("short pulse accepted");
  AST_PIN: assert property (low_cnt == 8'h19 |-> core.core_reset)
    else $error("long pulse ignored");
  AST_BOR: assert property (brownout_reset |=> core.core_reset)
    else $error("brown-out missed");
endmodule
bind rwi_top rwi_top_props u_props (.hclk, .hresetn, .ext_reset_pin_n, .brownout_reset,
  .watchdog_timeout, .return_pc, .core, .halted, .port_a_dir);

/* tb/tb.sv */
// Bench: registers over AHB-Lite, pin events, halt and resets.
// Assumes rwi_pins and the checker are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  import rwi_pkg::*;
  logic            hclk, hresetn, brownout_reset, watchdog_timeout, ext_reset_pin_n;
  logic            ext_irq_pin, halted, irq;
  logic [7:0]      timer0_count;
  logic [7:4]      port_b_pins;
  logic [31:0]     rd;
  logic            periph_pend;
  logic [12:0]     ret_pc;
  logic [5:0]      port_a_dir;
  logic [7:0]      port_b_dir, port_c_dir;
  int              miscompares, checked, pushes;
  rwi_ahb_in_type  ain;
  rwi_ahb_out_type aout;
  rwi_core_type    core;
  rwi_top DUT (.hclk, .hresetn, .ahb_in(ain), .ahb_out(aout), .ext_reset_pin_n,
    .brownout_reset, .watchdog_timeout, .ext_irq_pin, .timer0_count, .port_b_pins,
    .peripheral_irq_pending(periph_pend), .return_pc(ret_pc), .core, .halted,
    .port_a_dir, .port_b_dir, .port_c_dir, .irq);
  rwi_pins u_pins (.hclk, .ext_reset_pin_n, .ext_irq_pin);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @* ain.hready = aout.hreadyout;
  always @(negedge hclk) if (core.stack_push === 1'b1) pushes++;
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    ain.hsel <= 1'b1;
    ain.haddr <= {24'h000000, a};
    ain.htrans <= 2'h2;
    ain.hwrite <= w;
    do @(posedge hclk); while (aout.hreadyout !== 1'b1);
    ain.hsel <= 1'b0;
    ain.htrans <= 2'h0;
    ain.hwdata <= d;
    do @(posedge hclk); while (aout.hreadyout !== 1'b1);
    rd = aout.hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  // Outputs are looked at mid-cycle, clear of the edge
  task automatic look(input logic e, ref logic g, input string n);
    @(negedge hclk);
    `CHK(n, e, g)
    @(posedge hclk);
  endtask
  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    results;
  end
  initial begin
    hresetn = 1'b0;
    brownout_reset = 1'b0;
    watchdog_timeout = 1'b0;
    timer0_count = 8'hfe;
    port_b_pins = 4'h0;
    periph_pend = 1'b0;
    ret_pc = 13'h0123;
    ain.hsel = 1'b0;
    ain.haddr = 32'h0;
    ain.htrans = 2'h0;
    ain.hwrite = 1'b0;
    ain.hsize = 3'h2;
    ain.hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(8'h04, 32'hff, "option");
    rc(8'h00, 32'h00, "icon");
    rc(8'h08, 32'h03, "cause por");
    rc(8'h3c, 32'h00, "unmapped");
    $display("test reset done");
    bus(1'b1, 8'h00, 32'h10);
    u_pins.irq_pin(1'b1);
    rc(8'h00, 32'h12, "rise");
    u_pins.irq_pin(1'b0);
    rc(8'h00, 32'h12, "sticky");
    bus(1'b1, 8'h00, 32'h10);
    bus(1'b1, 8'h04, 32'hbf);
    u_pins.irq_pin(1'b1);
    rc(8'h00, 32'h10, "rise off");
    u_pins.irq_pin(1'b0);
    rc(8'h00, 32'h12, "fall");
    timer0_count <= 8'hff;
    @(posedge hclk);
    timer0_count <= 8'h00;
    port_b_pins <= 4'h8;
    repeat (2) @(posedge hclk);
    rc(8'h00, 32'h17, "t0 port");
    bus(1'b1, 8'h28, 32'h02);
    look(1'b1, irq, "irq on");
    bus(1'b1, 8'h28, 32'h00);
    look(1'b0, irq, "irq masked");
    bus(1'b1, 8'h24, 32'h1f);
    rc(8'h24, 32'h00, "w1c");
    $display("test flags done");
    bus(1'b1, 8'h00, 32'h90);
    u_pins.irq_pin(1'b1);
    bus(1'b1, 8'h0c, 32'h01);
    look(1'b1, halted, "halt");
    u_pins.irq_pin(1'b0);
    rc(8'h00, 32'h12, "wake icon");
    rc(8'h08, 32'h1a, "cause irq");
    bus(1'b1, 8'h00, 32'h10);
    u_pins.irq_pin(1'b1);
    bus(1'b1, 8'h0c, 32'h01);
    u_pins.irq_pin(1'b0);
    rc(8'h20, 32'h123, "continue");
    `CHK("one push", 1, pushes)
    bus(1'b1, 8'h00, 32'h40);
    periph_pend <= 1'b1;
    ret_pc <= 13'h0456;
    bus(1'b1, 8'h0c, 32'h01);
    @(posedge hclk);
    rc(8'h20, 32'h456, "periph wake");
    periph_pend <= 1'b0;
    $display("test wake done");
    bus(1'b1, 8'h1c, 32'h5a);
    bus(1'b1, 8'h0c, 32'h01);
    watchdog_timeout <= 1'b1;
    @(posedge hclk);
    watchdog_timeout <= 1'b0;
    rc(8'h08, 32'h10, "wdt wake");
    rc(8'h04, 32'hbf, "kept");
    bus(1'b1, 8'h0c, 32'h02);
    rc(8'h08, 32'h13, "clrwdt");
    bus(1'b1, 8'h10, 32'h00);
    rc(8'h10, 32'h00, "tris a");
    `CHK("dir a", 6'h00, port_a_dir)
    watchdog_timeout <= 1'b1;
    @(posedge hclk);
    watchdog_timeout <= 1'b0;
    repeat (2) @(posedge hclk);
    rc(8'h04, 32'hff, "wdt run");
    `CHK("dirs", 22'h3fffff, {port_a_dir, port_b_dir, port_c_dir})
    rc(8'h08, 32'h0d, "cause wdt");
    bus(1'b1, 8'h04, 32'hbf);
    u_pins.rst_low(10);
    rc(8'h04, 32'hbf, "glitch");
    u_pins.rst_low(30);
    repeat (3) @(posedge hclk);
    rc(8'h08, 32'h05, "pin run");
    brownout_reset <= 1'b1;
    repeat (3) @(posedge hclk);
    brownout_reset <= 1'b0;
    repeat (3) @(posedge hclk);
    rc(8'h08, 32'h17, "bor");
    rc(8'h1c, 32'h5a, "keep");
    $display("test resets done");
    results;
  end
endmodule
